// *** inc/tcet_defines.vh ***
// Constants shared by the commutation and external trigger block
`ifndef TCET_DEFINES_VH
`define TCET_DEFINES_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define TCET_OFF_CTRL2      8'h04
`define TCET_OFF_SMCFG      8'h08
`define TCET_OFF_EVENT      8'h14
`define TCET_OFF_CHAN_CFG   8'h20
`define TCET_OFF_CHAN_ACT   8'h24

// ************************************************************
// Control register two fields
// ************************************************************
`define TCET_CT_PRELOAD     0
`define TCET_CT_UPD_SEL     2
`define TCET_CT_DMA_SRC     3
`define TCET_CT_WMASK       32'h0000000d
`define TCET_CT_RESET       32'h00000000

// ************************************************************
// Slave mode configuration fields
// ************************************************************
`define TCET_SM_MODE_LO     0
`define TCET_SM_TSEL_LO     4
`define TCET_SM_FILT_LO     8
`define TCET_SM_PSC_LO      12
`define TCET_SM_ECM2        14
`define TCET_SM_POL         15
`define TCET_SM_WMASK       32'h0000fff7
`define TCET_SM_RESET       32'h00000000
`define TCET_SMS_EXT_CLK1   3'h7

// ************************************************************
// Event register and channel configuration layout
// ************************************************************
`define TCET_EV_COM_GEN     0
`define TCET_EV_FILTERED_EXT_TRIGGER_LVL    1
`define TCET_CH_WMASK       32'h000fff7f
`define TCET_CH_COMP_MASK   32'h0001ff77
`define TCET_CH_RESET       32'h00000000
`define TCET_CH_MODE_LO     8

// ************************************************************
// AXI4-Lite response codes
// ************************************************************
`define TCET_RESP_OKAY      2'h0
`define TCET_RESP_SLVERR    2'h2

`endif

// *** core/tcet_etr_filter.v ***
// Digital event-counter filter for the prescaled external trigger
`timescale 1ns/1ns
module tcet_etr_filter (
    // Clock and reset
    input  wire       i_ref_clk,
    input  wire       i_reset,
    // Filter input and control
    input  wire       i_sample_in,
    input  wire [3:0] i_code,
    // Filtered output
    output reg        o_filtered
);

    reg [4:0] div_cnt;    // Sampling divider, dead-time clock base
    reg [3:0] run_cnt;    // Consecutive differing samples seen
    wire      sample_en;  // Sampling strobe for this code
    wire [3:0] need;      // Required run length N

    // ************************************************************
    // Code decoding
    // ************************************************************
    // Log2 of sampling divider; dead-time clock equals kernel clock
    function [2:0] div_log2;
        input [3:0] c;
        begin
            case (c)
                4'h4, 4'h5:                 div_log2 = 3'h1;
                4'h6, 4'h7:                 div_log2 = 3'h2;
                4'h8, 4'h9:                 div_log2 = 3'h3;
                4'ha, 4'hb, 4'hc:           div_log2 = 3'h4;
                4'hd, 4'he, 4'hf:           div_log2 = 3'h5;
                default:                    div_log2 = 3'h0;
            endcase
        end
    endfunction

    // Number of consistent samples before the output moves
    function [3:0] run_len;
        input [3:0] c;
        begin
            case (c)
                4'h0:                       run_len = 4'h1;
                4'h1:                       run_len = 4'h2;
                4'h2:                       run_len = 4'h4;
                4'h4, 4'h6, 4'h8, 4'hb,
                4'hd:                       run_len = 4'h6;
                4'ha:                       run_len = 4'h5;
                default:                    run_len = 4'h8;
            endcase
        end
    endfunction

    assign sample_en = ((div_cnt & ((5'h01 << div_log2(i_code)) - 5'h01))
                        == 5'h00);
    assign need = run_len(i_code);

    // ************************************************************
    // Event counter
    // ************************************************************
    // Output changes only after a full run of differing samples
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            div_cnt    <= 5'h00;
            run_cnt    <= 4'h0;
            o_filtered <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 5'h01;
            if (sample_en) begin
                if (i_sample_in == o_filtered) begin
                    run_cnt <= 4'h0;
                end else if (run_cnt + 4'h1 >= need) begin
                    o_filtered <= i_sample_in;
                    run_cnt    <= 4'h0;
                end else begin
                    run_cnt <= run_cnt + 4'h1;
                end
            end
        end
    end

endmodule // tcet_etr_filter

// *** core/tcet_top.v ***
// Commutation shadow control, DMA source select, external trigger path
//
// Contract
// - DMA request on compare event or update
// - Preload bit defers channel bits to commutation
// - Update select adds trigger rising edge
// - Non-complementary channel ignores preload settings
// - Polarity bit inverts external trigger sense
// - Clock mode two counts filtered trigger edges
// - Mode two coexists with restart/pause/event
// - Clock mode two uses filtered trigger, mode one the trigger input
// - Prescaler divides by 1, 2, 4, 8
// - Filter moves after consistent sample run
// - Filter code picks rate and count
// - Slave mode seven counts trigger rises
`timescale 1ns/1ns
`include "tcet_defines.vh"
module tcet_top (
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_reset,
    // AXI4-Lite write address and data
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [7:0]  i_awaddr,
    input  wire        i_wvalid,
    output reg         o_wready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    // AXI4-Lite write response
    output reg         o_bvalid,
    input  wire        i_bready,
    output reg  [1:0]  o_bresp,
    // AXI4-Lite read
    input  wire        i_arvalid,
    output reg         o_arready,
    input  wire [7:0]  i_araddr,
    output reg         o_rvalid,
    input  wire        i_rready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    // Timer events from the rest of the timer
    input  wire [3:0]  i_cc_event,
    input  wire        i_update_event,
    input  wire        i_trigger_input_signal,
    // External trigger pin
    input  wire        i_external_trigger_pin,
    // Channel control outputs
    output reg  [3:0]  o_channel_output_enable,
    output reg  [2:0]  o_channel_complementary_enable,
    output reg  [11:0] o_output_compare_mode,
    output reg         o_commutation_event,
    // DMA requests
    output reg  [3:0]  o_dma_req,
    // Counter clock conditioning
    output wire        o_filtered_ext_trigger,
    output reg         o_count_tick,
    output reg         o_ext_clk_sel
);

    // ************************************************************
    // Declarations
    // ************************************************************
    reg  [31:0] ctrl2;         // Timer control two
    reg  [31:0] smcfg;         // Slave mode configuration
    reg  [31:0] chan_cfg;      // Written (preload) channel bits
    reg  [31:0] chan_act;      // Channel bits in force
    reg         aw_full;       // Write address held
    reg         w_full;        // Write data held
    reg  [7:0]  aw_addr;       // Held write address
    reg  [31:0] w_data;        // Held write data
    reg  [3:0]  w_strb;        // Held byte strobes
    reg         pin_meta;      // First synchroniser stage
    reg         pin_sync;      // Second synchroniser stage
    reg         pol_prev;      // Polarity-corrected level, last cycle
    reg  [2:0]  psc_cnt;       // Active edge counter for prescaler
    reg         trigger_input_signal_prev;     // Trigger input, last cycle
    reg         filtered_ext_trigger_prev;     // Filtered trigger, last cycle
    wire        wr_go;         // Write performed this cycle
    wire [2:0]  wr_sel;        // Decoded write target
    wire        com_gen_wr;    // Software commutation request
    wire        trigger_input_signal_rise;     // Rising edge of trigger input
    wire        com_evt;       // Commutation event
    wire        pol_lvl;       // Trigger after polarity
    wire        pol_rise;      // Active edge after polarity
    reg         psc_out;       // Prescaled external trigger
    wire        filtered_ext_trigger_rise;     // Active edge of filtered trigger
    wire [31:0] cfg_new;       // Channel bits masked to legal set

    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_CT   = 3'h1;
    localparam [2:0] SEL_SM   = 3'h2;
    localparam [2:0] SEL_EV   = 3'h3;
    localparam [2:0] SEL_CFG  = 3'h4;
    localparam [2:0] SEL_ACT  = 3'h5;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Register decode shared by read and write paths
    function [2:0] decode;
        input [7:0] a;
        begin
            case (a)
                `TCET_OFF_CTRL2:    decode = SEL_CT;
                `TCET_OFF_SMCFG:    decode = SEL_SM;
                `TCET_OFF_EVENT:    decode = SEL_EV;
                `TCET_OFF_CHAN_CFG: decode = SEL_CFG;
                `TCET_OFF_CHAN_ACT: decode = SEL_ACT;
                default:            decode = SEL_NONE;
            endcase
        end
    endfunction

    // Byte-lane merge limited to the writable bits
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        input [31:0] wmask;
        reg   [31:0] lanes;
        begin
            lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
            merge = (old & ~(lanes & wmask)) | (nw & lanes & wmask);
        end
    endfunction

    assign wr_go      = aw_full & w_full & ~o_bvalid;
    assign wr_sel     = decode(aw_addr);
    assign com_gen_wr = wr_go & (wr_sel == SEL_EV) & w_strb[0] &
                        w_data[`TCET_EV_COM_GEN];
    assign trigger_input_signal_rise  = i_trigger_input_signal & ~trigger_input_signal_prev;
    assign cfg_new    = chan_cfg & `TCET_CH_WMASK;

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    // Address and data are taken in any order; response after both
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `TCET_RESP_OKAY;
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h00000000;
            w_strb    <= 4'h0;
        end else begin
            // Capture address
            if (o_awready & i_awvalid) begin
                aw_full <= 1'b1;
                aw_addr <= i_awaddr;
            end
            // Capture data
            if (o_wready & i_wvalid) begin
                w_full <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            // Perform write and answer; unmapped gives slave error
            if (wr_go) begin
                aw_full  <= 1'b0;
                w_full   <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= (wr_sel == SEL_NONE) ? `TCET_RESP_SLVERR
                                                 : `TCET_RESP_OKAY;
            end
            if (o_bvalid & i_bready) begin
                o_bvalid <= 1'b0;
            end
            // Each ready only while its own channel holds nothing and no answer pends
            o_awready <= ~(aw_full | (o_awready & i_awvalid)) &
                         ~o_bvalid & ~wr_go;
            o_wready  <= ~(w_full | (o_wready & i_wvalid)) &
                         ~o_bvalid & ~wr_go;
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    // One cycle from address handshake to data
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `TCET_RESP_OKAY;
        end else begin
            if (o_arready & i_arvalid) begin
                o_rvalid <= 1'b1;
                o_rresp  <= `TCET_RESP_OKAY;
                case (decode(i_araddr))
                    SEL_CT:  o_rdata <= ctrl2;
                    SEL_SM:  o_rdata <= smcfg;
                    SEL_EV:  o_rdata <= {30'h00000000,
                                         o_filtered_ext_trigger, 1'b0};
                    SEL_CFG: o_rdata <= chan_cfg;
                    SEL_ACT: o_rdata <= chan_act;
                    default: begin
                        o_rdata <= 32'h00000000;
                        o_rresp <= `TCET_RESP_SLVERR;
                    end
                endcase
            end
            if (o_rvalid & i_rready) begin
                o_rvalid <= 1'b0;
            end
            o_arready <= ~(o_arready & i_arvalid) & ~o_rvalid;
        end
    end

    // ************************************************************
    // Software registers
    // ************************************************************
    // Reserved bits are masked, so they always read as zero
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            ctrl2    <= `TCET_CT_RESET;
            smcfg    <= `TCET_SM_RESET;
            chan_cfg <= `TCET_CH_RESET;
        end else if (wr_go) begin
            case (wr_sel)
                // Reserved bit one is kept at zero by the mask
                SEL_CT:  ctrl2 <= merge(ctrl2, w_data, w_strb,
                                        `TCET_CT_WMASK);
                SEL_SM:  smcfg <= merge(smcfg, w_data, w_strb,
                                        `TCET_SM_WMASK);
                SEL_CFG: chan_cfg <= merge(chan_cfg, w_data, w_strb,
                                           `TCET_CH_WMASK);
                default: ctrl2 <= ctrl2;
            endcase
        end
    end

    // ************************************************************
    // Commutation shadow transfer
    // ************************************************************
    // Software request always, trigger edge only when selected
    assign com_evt = com_gen_wr |
                     (ctrl2[`TCET_CT_UPD_SEL] & trigger_input_signal_rise);

    // Channel four has no complementary output and always follows
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            chan_act  <= `TCET_CH_RESET;
            trigger_input_signal_prev <= 1'b0;
        end else begin
            trigger_input_signal_prev <= i_trigger_input_signal;
            if (~ctrl2[`TCET_CT_PRELOAD] | com_evt) begin
                chan_act <= cfg_new;
            end else begin
                chan_act <= (chan_act & `TCET_CH_COMP_MASK) |
                            (cfg_new & ~`TCET_CH_COMP_MASK);
            end
        end
    end

    // Channel outputs drawn from the bits in force
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_channel_output_enable        <= 4'h0;
            o_channel_complementary_enable <= 3'h0;
            o_output_compare_mode          <= 12'h000;
            o_commutation_event            <= 1'b0;
        end else begin
            o_channel_output_enable        <= chan_act[3:0];
            o_channel_complementary_enable <= chan_act[6:4];
            o_output_compare_mode          <=
                chan_act[`TCET_CH_MODE_LO +: 12];
            o_commutation_event <= com_evt & ctrl2[`TCET_CT_PRELOAD];
        end
    end

    // ************************************************************
    // DMA request source
    // ************************************************************
    // Select either per-channel compare or the shared update event
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_dma_req <= 4'h0;
        end else if (ctrl2[`TCET_CT_DMA_SRC]) begin
            o_dma_req <= {4{i_update_event}};
        end else begin
            o_dma_req <= i_cc_event;
        end
    end

    // ************************************************************
    // External trigger synchroniser, polarity and prescaler
    // ************************************************************
    // Two flops keep metastability away from the edge logic
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= i_external_trigger_pin;
            pin_sync <= pin_meta;
        end
    end

    assign pol_lvl  = pin_sync ^ smcfg[`TCET_SM_POL];
    assign pol_rise = pol_lvl & ~pol_prev;

    // Edge counter bits give divide by 2, 4 and 8
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            pol_prev <= 1'b0;
            psc_cnt  <= 3'h0;
        end else begin
            pol_prev <= pol_lvl;
            if (pol_rise) begin
                psc_cnt <= psc_cnt + 3'h1;
            end
        end
    end

    // Input rate must stay below a quarter kernel rate
    always @* begin
        case (smcfg[`TCET_SM_PSC_LO +: 2])
            2'h1:    psc_out = psc_cnt[0];
            2'h2:    psc_out = psc_cnt[1];
            2'h3:    psc_out = psc_cnt[2];
            default: psc_out = pol_lvl;
        endcase
    end

    // ************************************************************
    // Digital filter
    // ************************************************************
    tcet_etr_filter u_filter (
        .i_ref_clk   (i_ref_clk),
        .i_reset     (i_reset),
        .i_sample_in (psc_out),
        .i_code      (smcfg[`TCET_SM_FILT_LO +: 4]),
        .o_filtered  (o_filtered_ext_trigger)
    );

    assign filtered_ext_trigger_rise = o_filtered_ext_trigger & ~filtered_ext_trigger_prev;

    // ************************************************************
    // Counter clock selection
    // ************************************************************
    // Mode two wins over mode one and runs beside other slave modes
    always @(posedge i_ref_clk) begin
        if (i_reset) begin
            filtered_ext_trigger_prev     <= 1'b0;
            o_count_tick  <= 1'b0;
            o_ext_clk_sel <= 1'b0;
        end else begin
            filtered_ext_trigger_prev     <= o_filtered_ext_trigger;
            o_ext_clk_sel <= smcfg[`TCET_SM_ECM2];
            if (smcfg[`TCET_SM_ECM2]) begin
                o_count_tick <= filtered_ext_trigger_rise;
            end else if (smcfg[`TCET_SM_MODE_LO +: 3] ==
                         `TCET_SMS_EXT_CLK1) begin
                o_count_tick <= trigger_input_signal_rise;
            end else begin
                o_count_tick <= 1'b0;
            end
        end
    end

endmodule // tcet_top

// *** testbench/tcet_chk_asserts.sv ***
// Checker for the commutation and external trigger block
`timescale 1ns/1ns
module tcet_chk (
    // Clock and reset
    input wire        i_ref_clk,
    input wire        i_reset,
    // Bus
    input wire        i_arvalid,
    input wire        o_arready,
    input wire        o_rvalid,
    input wire        i_rready,
    input wire [31:0] o_rdata,
    input wire        o_bvalid,
    input wire        i_bready,
    input wire [1:0]  o_bresp,
    // Timer side
    input wire [3:0]  i_cc_event,
    input wire        i_update_event,
    input wire [3:0]  o_dma_req,
    input wire        o_commutation_event,
    input wire        o_filtered_ext_trigger,
    input wire        o_count_tick,
    input wire        o_ext_clk_sel
);
    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    AST_DMA_SRC: assert property (o_dma_req == 4'h0 ||
        o_dma_req == $past(i_cc_event) ||
        o_dma_req == {4{$past(i_update_event)}})
        else $error("dma request without source");
    AST_COMM_ONE: assert property (o_commutation_event |=>
        !o_commutation_event) else $error("commutation pulse too long");
    AST_TICK: assert property ($rose(o_filtered_ext_trigger) &&
        o_ext_clk_sel && $past(o_ext_clk_sel) |-> ##[0:2] o_count_tick)
        else $error("filtered edge not counted");
    AST_FILT: assert property ($changed(o_filtered_ext_trigger) |=>
        $stable(o_filtered_ext_trigger)) else $error("filter too fast");
    AST_SEL_WR: assert property ($changed(o_ext_clk_sel) |->
        o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2))
        else $error("clock mode moved without a write");
    AST_BHOLD: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
    AST_RHOLD: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
    AST_RLAT: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
endmodule // tcet_chk

bind tcet_top tcet_chk u_chk (.*);

// *** testbench/tcet_etr_src.sv ***
// External trigger source driving the trigger pin
`timescale 1ns/1ns
module tcet_etr_src (
    // Clock and control
    input  wire       i_ref_clk,
    input  wire       i_run,
    input  wire [3:0] i_half,
    // Pin
    output reg        o_pin
);
    reg [3:0] cnt = 4'h0; // Cycles left in this half period
    initial o_pin = 1'b0;
    // Half period of two or more keeps the rate at or below a quarter of the clock
    always @(posedge i_ref_clk) begin
        if (!i_run) begin
            o_pin <= 1'b0; // Line idles low between bursts
            cnt <= 4'h0;
        end else if (cnt == 4'h0) begin
            o_pin <= ~o_pin;
            cnt <= i_half - 4'h1;
        end else begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule // tcet_etr_src

// *** testbench/tcet_top_tb.sv ***
// Self-checking testbench for the commutation and trigger block
`timescale 1ns/1ns
`include "tcet_defines.vh"
module tcet_top_tb;
    localparam [7:0] a_ct = `TCET_OFF_CTRL2;
    localparam [7:0] a_sm = `TCET_OFF_SMCFG;
    localparam [7:0] a_ca = `TCET_OFF_CHAN_ACT;
    reg clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
    reg arv = 1'b0, rry = 1'b0, upd = 1'b0, trg = 1'b0, run = 1'b0;
    reg probe = 1'b0;
    reg [7:0] awa = 8'h0, ara = 8'h0;
    reg [31:0] wd = 32'h0, nt = 32'h0, base = 32'h0, v, w, e;
    reg [3:0] cc = 4'h0, half = 4'h2, c;
    reg [33:0] got, ck;
    reg [33:0] exp_q[$];
    integer err_total = 0, checks_done = 0, p;
    wire awr, wr_r, bv, arr, rv, filt, tick, pin;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [3:0] dma;
    always #2 clk = ~clk;
    tcet_etr_src u_src (.i_ref_clk(clk), .i_run(run), .i_half(half),
        .o_pin(pin));
    tcet_top uut (.i_ref_clk(clk), .i_reset(rst), .i_awvalid(awv),
        .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr_r),
        .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bry),
        .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
        .o_rvalid(rv), .i_rready(rry), .o_rdata(rdat), .o_rresp(rr),
        .i_cc_event(cc), .i_update_event(upd),
        .i_trigger_input_signal(trg), .i_external_trigger_pin(pin),
        .o_channel_output_enable(), .o_channel_complementary_enable(),
        .o_output_compare_mode(), .o_commutation_event(),
        .o_dma_req(dma), .o_filtered_ext_trigger(filt),
        .o_count_tick(tick), .o_ext_clk_sel());
    always @(posedge clk) if (tick === 1'b1) nt <= nt + 32'h1;
    // Compare each result with the oldest note
    always @(negedge clk) begin
        if (!rst && (probe || dma !== 4'h0 || (bv && bry) || (rv && rry)))
        begin
            if (probe) got = {2'b01, nt - base};
            else if (dma !== 4'h0) got = {2'b11, 28'h0, dma};
            else if (rv) got = {rr, rdat};
            else got = {br, 32'h0};
            ck = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
            checks_done = checks_done + 1;
            if (got !== ck) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: %h not %h", $time, got, ck);
            end
        end
    end
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        reg pa, pw;
        begin
            exp_q.push_back({r, 32'h0});
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            while (pa || pw) begin
                @(negedge clk);
                if (awr) pa = 1'b0;
                if (wr_r) pw = 1'b0;
                @(posedge clk);
                awv <= pa;
                wv <= pw;
            end
            @(posedge clk);
            bry <= 1'b1;
            do @(negedge clk); while (!bv);
            @(posedge clk);
            bry <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [33:0] x);
        begin
            exp_q.push_back(x);
            ara <= a;
            arv <= 1'b1;
            do @(negedge clk); while (!arr);
            @(posedge clk);
            arv <= 1'b0;
            @(posedge clk);
            rry <= 1'b1;
            do @(negedge clk); while (!rv);
            @(posedge clk);
            rry <= 1'b0;
        end
    endtask
    // Pulse timer events; a nonzero x is the expected request
    task ev(input [3:0] ci, input u, input t, input [3:0] x);
        begin
            if (x != 4'h0) exp_q.push_back({2'b11, 28'h0, x});
            cc <= ci;
            upd <= u;
            trg <= t;
            @(posedge clk);
            cc <= 4'h0;
            upd <= 1'b0;
            trg <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    // Configure, pulse the trigger, run the pin, count ticks
    task ec(input [31:0] s, input [3:0] h, input [31:0] x);
        begin
            wr(a_sm, s, 2'h0);
            repeat (10) @(posedge clk);
            @(negedge clk);
            base = nt;
            @(posedge clk);
            ev(4'h0, 1'b0, 1'b1, 4'h0);
            half <= h;
            run <= 1'b1;
            repeat (64) @(posedge clk);
            run <= 1'b0;
            repeat (40) @(posedge clk);
            exp_q.push_back({2'b01, x});
            probe <= 1'b1;
            @(posedge clk);
            probe <= 1'b0;
            @(posedge clk);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_total);
            if (err_total == 0 && checks_done > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Watchdog, well past the test span
    initial begin
        #200000;
        err_total = err_total + 1;
        $display("wrong value at %0t: timeout", $time);
        close_out;
    end
    initial begin
        v = $urandom(4183);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(a_sm, 34'h0);
        rd(8'h40, {`TCET_RESP_SLVERR, 32'h0});
        wr(8'h40, 32'h1, `TCET_RESP_SLVERR);
        wr(a_ct, 32'hfffffffd, 2'h0);
        rd(a_ct, {2'h0, `TCET_CT_WMASK});
        v = $urandom & 32'hffffbfff;
        wr(a_sm, v, 2'h0);
        rd(a_sm, {2'h0, v & `TCET_SM_WMASK});
        $display("register test done");
        wr(a_ct, 32'h0, 2'h0);
        v = $urandom;
        wr(`TCET_OFF_CHAN_CFG, v, 2'h0);
        rd(a_ca, {2'h0, v & `TCET_CH_WMASK});
        wr(a_ct, 32'h1, 2'h0);
        w = $urandom;
        wr(`TCET_OFF_CHAN_CFG, w, 2'h0);
        e = (v & `TCET_CH_COMP_MASK) | (w & 32'h000e0008);
        ev(4'h0, 1'b0, 1'b1, 4'h0);
        rd(a_ca, {2'h0, e});
        wr(`TCET_OFF_EVENT, 32'h1, 2'h0);
        rd(a_ca, {2'h0, w & `TCET_CH_WMASK});
        wr(a_ct, 32'h5, 2'h0);
        v = $urandom;
        wr(`TCET_OFF_CHAN_CFG, v, 2'h0);
        ev(4'h0, 1'b0, 1'b1, 4'h0);
        rd(a_ca, {2'h0, v & `TCET_CH_WMASK});
        $display("commutation test done");
        wr(a_ct, 32'h0, 2'h0);
        c = $urandom_range(15, 1);
        ev(c, 1'b1, 1'b0, c);
        wr(a_ct, 32'h8, 2'h0);
        ev(c, 1'b1, 1'b0, 4'hf);
        ev(c, 1'b0, 1'b0, 4'h0);
        $display("dma test done");
        for (p = 0; p < 4; p = p + 1)
            ec(32'h4000 | (p << 12), 4'h2, 32'h10 >> p);
        wr(a_sm, 32'h8000, 2'h0);
        rd(`TCET_OFF_EVENT, {2'h0, 32'h2});
        ec(32'h4300, 4'h4, 32'h0);
        ec(32'h4100, 4'h4, 32'h8);
        ec(32'h7, 4'h2, 32'h1);
        ec(32'h4007, 4'h2, 32'h10);
        $display("trigger test done");
        close_out;
    end
endmodule // tcet_top_tb
